// *** pietc_pkg.sv ***
package pietc_pkg;

  // Sizes
  localparam int          PORT_COUNT      = 3;
  localparam int          APB_AW          = 8;
  localparam int          APB_DW          = 32;
  localparam int          VID_W           = 12;
  localparam int          SETUP_W         = 6;

  // Register offsets; the per-port ones are indexed by port number
  localparam logic [7:0]  CTRL0_OFS [3]   = '{8'h10, 8'h20, 8'h30};
  localparam logic [7:0]  PORT_DEFAULT_VLAN_ID_OFS  [3]   = '{8'h14, 8'h24, 8'h34};
  localparam logic [7:0]  SPLIT2_OFS[3]   = '{8'h18, 8'h28, 8'h38};
  localparam logic [7:0]  STATUS_OFS      = 8'h40;
  localparam logic [7:0]  TAG_SETUP_OFS   = 8'h44;

  // Ingress and egress control fields
  localparam int          STORM_BIT       = 7;
  localparam int          DSCP_BIT        = 6;
  localparam int          P1P_BIT         = 5;
  localparam int          PRIO_HI         = 4;
  localparam int          PRIO_LO         = 3;
  localparam int          INSERT_BIT      = 2;
  localparam int          REMOVE_BIT      = 1;
  localparam int          SPLIT4_BIT      = 0;
  localparam int          SPLIT2_BIT      = 7;

  // Status fields
  localparam int          STAT_CONFL_LO   = 0;
  localparam int          STAT_READY_BIT  = 3;

  // Reset values, and the value of a complete tag setup
  localparam logic [7:0]  CTRL0_RST       = 8'h00;
  localparam logic [7:0]  SPLIT2_RST      = 8'h00;
  localparam logic [11:0] PORT_DEFAULT_VLAN_ID_RST        = 12'h001;
  localparam logic [5:0]  TAG_SETUP_RST   = 6'h00;
  localparam logic [5:0]  TAG_SETUP_FULL  = 6'h3f;

  typedef logic [1:0] pietc_prio_t;
  typedef logic [1:0] pietc_port_t;

endpackage : pietc_pkg

// *** pietc_cfg_if.sv ***
interface pietc_cfg_if;
  import pietc_pkg::*;

  logic        storm_en;
  logic        dscp_en;
  logic        p1p_en;
  pietc_prio_t port_prio;

  modport src (output storm_en, dscp_en, p1p_en, port_prio);
  modport dst (input  storm_en, dscp_en, p1p_en, port_prio);

endinterface : pietc_cfg_if

// *** pietc_ingress.sv ***
module pietc_ingress (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // Port configuration
  pietc_cfg_if.dst                  cfg,
  // Received frame summary
  input  wire logic                 rx_valid,
  input  wire logic                 rx_bcast,
  input  wire logic                 rx_storm_over,
  input  wire logic                 rx_ipv4,
  input  wire pietc_pkg::pietc_prio_t rx_dscp_prio,
  input  wire logic                 rx_tagged,
  input  wire pietc_pkg::pietc_prio_t rx_tag_prio,
  // Classification result
  output logic                      cls_valid,
  output pietc_pkg::pietc_prio_t    cls_queue,
  output logic                      cls_drop
);
  import pietc_pkg::*;

  logic        dscp_hit;
  logic        p1p_hit;
  pietc_prio_t queue_d;

  always_comb begin
    dscp_hit = cfg.dscp_en & rx_ipv4;                      // see [RULE2]
    p1p_hit  = cfg.p1p_en & rx_tagged;                     // see [RULE3]
    queue_d  = cfg.port_prio;                              // see [RULE4]
    if (dscp_hit | p1p_hit) begin
      // Both results merge bitwise, overriding the port default
      queue_d = (dscp_hit ? rx_dscp_prio : 2'h0)
              | (p1p_hit ? rx_tag_prio : 2'h0);            // see [RULE5]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cls_valid <= 1'b0;
      cls_queue <= 2'h0;
      cls_drop  <= 1'b0;
    end else begin
      cls_valid <= rx_valid;
      cls_queue <= queue_d;
      cls_drop  <= rx_valid & rx_bcast & rx_storm_over
                 & cfg.storm_en;                           // see [RULE1]
    end
  end

  AST_STORM_DROP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rx_valid |-> ##1 (cls_drop == $past(rx_bcast & rx_storm_over
                                        & cfg.storm_en))) // see [RULE1]
    else $error("storm drop does not follow enable");
  AST_DSCP_ONLY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rx_valid && cfg.dscp_en && rx_ipv4 && !(cfg.p1p_en && rx_tagged))
    |=> cls_queue == $past(rx_dscp_prio)) // see [RULE2]
    else $error("dscp class not applied");
  AST_P1P_ONLY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rx_valid && cfg.p1p_en && rx_tagged && !(cfg.dscp_en && rx_ipv4))
    |=> cls_queue == $past(rx_tag_prio)) // see [RULE3]
    else $error("user priority class not applied");
  AST_PORT_PRIO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rx_valid && !(cfg.dscp_en && rx_ipv4) && !(cfg.p1p_en && rx_tagged))
    |=> cls_queue == $past(cfg.port_prio)) // see [RULE4]
    else $error("port default queue not applied");
  AST_OR_MERGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rx_valid && cfg.dscp_en && rx_ipv4 && cfg.p1p_en && rx_tagged)
    |=> cls_queue == ($past(rx_dscp_prio) | $past(rx_tag_prio))) // see [RULE5]
    else $error("merged class wrong");

endmodule : pietc_ingress

// *** pietc_top.sv ***
// Notes on behaviour
// [RULE1] Bit 7 enables broadcast storm protection
// [RULE2] Bit 6 enables DiffServ classification for IPv4
// [RULE3] Bit 5 enables 802.1p user priority classification
// [RULE4] Bits 4-3 give fallback queue 0 to 3
// [RULE5] Both results ORed, replacing port default queue
// [RULE6] Bit 2 tags frames received untagged
// [RULE7] Inserted tag carries ingress port VLAN id
// [RULE8] Software programs tag setup bits before insertion
// [RULE9] Bit 1 strips tags from tagged frames
// [RULE10] Bit 0 splits transmit queue into four
// [RULE11] Software never sets both queue splits
// [RULE12] Three identical registers at 0x10, 0x20, 0x30
// [RULE13] Two-way split exclusive with four-way split
// [RULE14] Port VLAN id from default tag registers
// [RULE15] Tag change on egress recomputes frame checksum
module pietc_top #(
  parameter int NPORT = pietc_pkg::PORT_COUNT
) (
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [pietc_pkg::APB_AW-1:0]  paddr,
  input  wire logic [pietc_pkg::APB_DW-1:0]  pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [pietc_pkg::APB_DW-1:0]  prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Ingress frame summaries, one lane per port
  input  wire logic [NPORT-1:0]              rx_valid,
  input  wire logic [NPORT-1:0]              rx_bcast,
  input  wire logic [NPORT-1:0]              rx_storm_over,
  input  wire logic [NPORT-1:0]              rx_ipv4,
  input  wire pietc_pkg::pietc_prio_t [NPORT-1:0] rx_dscp_prio,
  input  wire logic [NPORT-1:0]              rx_tagged,
  input  wire pietc_pkg::pietc_prio_t [NPORT-1:0] rx_tag_prio,
  // Ingress classification results
  output logic      [NPORT-1:0]              cls_valid,
  output pietc_pkg::pietc_prio_t [NPORT-1:0] cls_queue,
  output logic      [NPORT-1:0]              cls_drop,
  // Egress frame request
  input  wire logic                          tx_valid,
  input  wire pietc_pkg::pietc_port_t        tx_port,
  input  wire pietc_pkg::pietc_port_t        tx_src_port,
  input  wire logic                          tx_rx_tagged,
  // Egress edit decision
  output logic                               tx_edit_valid,
  output logic                               tx_insert_tag,
  output logic                               tx_strip_tag,
  output logic      [pietc_pkg::VID_W-1:0]   tx_tag_vid,
  output logic                               tx_fcs_redo,
  // Transmit queue organisation per port
  output logic      [NPORT-1:0]              egress_queue_four_way_split,
  output logic      [NPORT-1:0]              egress_queue_two_way_split
);
  import pietc_pkg::*;

  if (NPORT < 1 || NPORT > PORT_COUNT) begin : g_bad_nport
    $error("NPORT must lie between 1 and 3");
  end

  logic [7:0]       ctrl0_q  [NPORT];
  logic [7:0]       split2_q [NPORT];
  logic [VID_W-1:0] port_default_vlan_id_q   [NPORT];
  logic [5:0]       setup_q;

  logic             apb_wr;
  logic             apb_rd;
  logic [NPORT-1:0] hit_ctrl0;
  logic [NPORT-1:0] hit_port_default_vlan_id;
  logic [NPORT-1:0] hit_split2;
  logic             hit_status;
  logic             hit_setup;
  logic             hit_any;
  logic [NPORT-1:0] conflict;
  logic             setup_ready;
  logic [APB_DW-1:0] rdata_d;

  // Zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign apb_wr  = psel & penable & pwrite;
  assign apb_rd  = psel & penable & ~pwrite;
  assign pslverr = psel & penable & ~hit_any;

  assign hit_status = (paddr == STATUS_OFS);
  assign hit_setup  = (paddr == TAG_SETUP_OFS);
  assign hit_any    = (|hit_ctrl0) | (|hit_port_default_vlan_id) | (|hit_split2)
                    | hit_status | hit_setup;
  assign setup_ready = (setup_q == TAG_SETUP_FULL);

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    pietc_cfg_if cfg_if ();

    assign hit_ctrl0[p]  = (paddr == CTRL0_OFS[p]);        // see [RULE12]
    assign hit_port_default_vlan_id[p]   = (paddr == PORT_DEFAULT_VLAN_ID_OFS[p]);
    assign hit_split2[p] = (paddr == SPLIT2_OFS[p]);

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        ctrl0_q[p] <= CTRL0_RST;
      end else if (apb_wr && hit_ctrl0[p] && pstrb[0]) begin
        ctrl0_q[p] <= pwdata[7:0];                         // see [RULE12]
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        split2_q[p] <= SPLIT2_RST;
      end else if (apb_wr && hit_split2[p] && pstrb[0]) begin
        split2_q[p] <= {pwdata[SPLIT2_BIT], 7'h00};
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        port_default_vlan_id_q[p] <= PORT_DEFAULT_VLAN_ID_RST;
      end else if (apb_wr && hit_port_default_vlan_id[p]) begin
        if (pstrb[0]) begin
          port_default_vlan_id_q[p][7:0] <= pwdata[7:0];                   // see [RULE14]
        end
        if (pstrb[1]) begin
          port_default_vlan_id_q[p][11:8] <= pwdata[11:8];                 // see [RULE14]
        end
      end
    end

    // Both splits set is a software error; four-way wins and status flags it
    assign conflict[p] = ctrl0_q[p][SPLIT4_BIT] & split2_q[p][SPLIT2_BIT];

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        egress_queue_four_way_split[p] <= 1'b0;
        egress_queue_two_way_split[p]  <= 1'b0;
      end else begin
        egress_queue_four_way_split[p] <= ctrl0_q[p][SPLIT4_BIT]; // see [RULE10]
        egress_queue_two_way_split[p]  <= split2_q[p][SPLIT2_BIT]
                                        & ~ctrl0_q[p][SPLIT4_BIT]; // see [RULE13]
      end
    end

    assign cfg_if.storm_en  = ctrl0_q[p][STORM_BIT];
    assign cfg_if.dscp_en   = ctrl0_q[p][DSCP_BIT];
    assign cfg_if.p1p_en    = ctrl0_q[p][P1P_BIT];
    assign cfg_if.port_prio = ctrl0_q[p][PRIO_HI:PRIO_LO];

    pietc_ingress u_ingress (
      .clk_sys       (clk_sys),
      .rst_n         (rst_n),
      .cfg           (cfg_if),
      .rx_valid      (rx_valid[p]),
      .rx_bcast      (rx_bcast[p]),
      .rx_storm_over (rx_storm_over[p]),
      .rx_ipv4       (rx_ipv4[p]),
      .rx_dscp_prio  (rx_dscp_prio[p]),
      .rx_tagged     (rx_tagged[p]),
      .rx_tag_prio   (rx_tag_prio[p]),
      .cls_valid     (cls_valid[p]),
      .cls_queue     (cls_queue[p]),
      .cls_drop      (cls_drop[p])
    );

    AST_FOUR_SPLIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ##1 egress_queue_four_way_split[p] == $past(ctrl0_q[p][SPLIT4_BIT]))
      // see [RULE10]
      else $error("four-way split does not follow its bit");
    AST_SPLIT_EXCL: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !(egress_queue_four_way_split[p] && egress_queue_two_way_split[p]))
      // see [RULE13]
      else $error("both queue splits active");
    AST_CTRL0_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (apb_wr && paddr == CTRL0_OFS[p] && pstrb[0])
      |=> ctrl0_q[p] == $past(pwdata[7:0])) // see [RULE12]
      else $error("port control write lost");
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      setup_q <= TAG_SETUP_RST;
    end else if (apb_wr && hit_setup && pstrb[0]) begin
      setup_q <= pwdata[SETUP_W-1:0];
    end
  end

  always_comb begin
    rdata_d = '0;
    for (int i = 0; i < NPORT; i++) begin
      if (hit_ctrl0[i]) begin
        rdata_d[7:0] = ctrl0_q[i];
      end
      if (hit_port_default_vlan_id[i]) begin
        rdata_d[VID_W-1:0] = port_default_vlan_id_q[i];
      end
      if (hit_split2[i]) begin
        rdata_d[7:0] = split2_q[i];
      end
    end
    if (hit_status) begin
      rdata_d[STAT_CONFL_LO +: NPORT] = conflict;
      rdata_d[STAT_READY_BIT]         = setup_ready;
    end
    if (hit_setup) begin
      rdata_d[SETUP_W-1:0] = setup_q;
    end
  end

  // Read data is combinational so it is valid in the single access cycle
  assign prdata = apb_rd ? rdata_d : '0;

  // Egress edit decision, registered one cycle after the request
  logic             tx_port_ok;
  logic             tx_src_ok;
  logic [7:0]       tx_ctrl;
  logic [VID_W-1:0] src_vid;
  logic             ins_d;
  logic             strip_d;

  assign tx_port_ok = (32'(tx_port) < NPORT);
  assign tx_src_ok  = (32'(tx_src_port) < NPORT);

  always_comb begin
    tx_ctrl = 8'h00;
    src_vid = '0;
    for (int i = 0; i < NPORT; i++) begin
      if (tx_port_ok && 32'(tx_port) == i) begin
        tx_ctrl = ctrl0_q[i];
      end
      if (tx_src_ok && 32'(tx_src_port) == i) begin
        src_vid = port_default_vlan_id_q[i];                               // see [RULE7]
      end
    end
  end

  // Insertion stays off until software has completed the tag setup field
  assign ins_d   = tx_ctrl[INSERT_BIT] & ~tx_rx_tagged
                 & setup_ready & tx_src_ok;                // see [RULE6] [RULE8]
  assign strip_d = tx_ctrl[REMOVE_BIT] & tx_rx_tagged;     // see [RULE9]

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_edit_valid <= 1'b0;
      tx_insert_tag <= 1'b0;
      tx_strip_tag  <= 1'b0;
      tx_fcs_redo   <= 1'b0;
    end else begin
      tx_edit_valid <= tx_valid;
      tx_insert_tag <= tx_valid & ins_d;                   // see [RULE6]
      tx_strip_tag  <= tx_valid & strip_d;                 // see [RULE9]
      tx_fcs_redo   <= tx_valid & (ins_d | strip_d);       // see [RULE15]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_tag_vid <= '0;
    end else if (tx_valid) begin
      tx_tag_vid <= src_vid;                               // see [RULE7] [RULE14]
    end
  end

  AST_INSERT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tx_valid && tx_port_ok && tx_src_ok && !tx_rx_tagged && setup_ready
     && tx_ctrl[INSERT_BIT]) |=> tx_insert_tag) // see [RULE6]
    else $error("untagged frame not tagged");
  AST_NO_RETAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tx_valid && tx_rx_tagged) |=> !tx_insert_tag) // see [RULE6]
    else $error("tagged frame given a second tag");
  AST_INGRESS_VID: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tx_valid && tx_src_ok) |=> tx_tag_vid == $past(src_vid)) // see [RULE7]
    else $error("inserted id is not the ingress port id");
  AST_STRIP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tx_valid |=> tx_strip_tag == $past(tx_rx_tagged && tx_ctrl[REMOVE_BIT]))
    // see [RULE9]
    else $error("tag removal wrong");
  AST_PORT_DEFAULT_VLAN_ID_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (apb_wr && hit_port_default_vlan_id[0] && pstrb[1:0] == 2'h3)
    |=> port_default_vlan_id_q[0] == $past(pwdata[VID_W-1:0])) // see [RULE14]
    else $error("default id write lost");
  AST_FCS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tx_edit_valid |-> tx_fcs_redo == (tx_insert_tag || tx_strip_tag))
    // see [RULE15]
    else $error("checksum redo does not match edit");

endmodule : pietc_top

// *** test_port_ingress_class_egress_tag_ctrl.sv ***
module test_port_ingress_class_egress_tag_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import pietc_pkg::*;

  // Clock and reset
  logic                   clk_sys;
  logic                   rst_n;
  // APB
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [APB_AW-1:0]      paddr;
  logic [APB_DW-1:0]      pwdata;
  logic [3:0]             pstrb;
  logic [APB_DW-1:0]      prdata;
  logic                   pready;
  logic                   pslverr;
  // Ingress
  logic [2:0]             rx_valid;
  logic [2:0]             rx_bcast;
  logic [2:0]             rx_storm_over;
  logic [2:0]             rx_ipv4;
  logic [2:0]             rx_tagged;
  pietc_prio_t [2:0]      rx_dscp_prio;
  pietc_prio_t [2:0]      rx_tag_prio;
  logic [2:0]             cls_valid;
  pietc_prio_t [2:0]      cls_queue;
  logic [2:0]             cls_drop;
  // Egress
  logic                   tx_valid;
  pietc_port_t            tx_port;
  pietc_port_t            tx_src_port;
  logic                   tx_rx_tagged;
  logic                   tx_edit_valid;
  logic                   tx_insert_tag;
  logic                   tx_strip_tag;
  logic [VID_W-1:0]       tx_tag_vid;
  logic                   tx_fcs_redo;
  logic [2:0]             egress_queue_four_way_split;
  logic [2:0]             egress_queue_two_way_split;
  // Bench state
  int                     fail_count;
  int                     samples_checked;
  int                     cycles;
  logic [31:0]            rd;
  logic                   err;
  logic [VID_W-1:0]       vid [3];
  logic [7:0]             ectl [3];

  pietc_top #(.NPORT(3)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_bcast(rx_bcast),
    .rx_storm_over(rx_storm_over), .rx_ipv4(rx_ipv4),
    .rx_dscp_prio(rx_dscp_prio), .rx_tagged(rx_tagged),
    .rx_tag_prio(rx_tag_prio), .cls_valid(cls_valid),
    .cls_queue(cls_queue), .cls_drop(cls_drop), .tx_valid(tx_valid),
    .tx_port(tx_port), .tx_src_port(tx_src_port),
    .tx_rx_tagged(tx_rx_tagged), .tx_edit_valid(tx_edit_valid),
    .tx_insert_tag(tx_insert_tag), .tx_strip_tag(tx_strip_tag),
    .tx_tag_vid(tx_tag_vid), .tx_fcs_redo(tx_fcs_redo),
    .egress_queue_four_way_split(egress_queue_four_way_split),
    .egress_queue_two_way_split(egress_queue_two_way_split));

  always #2.5 clk_sys = ~clk_sys;

  task automatic end_of_test;
    $display("Mismatches %0d, checks %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Waits on pready rather than assuming the zero-wait answer
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    check(pready, 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk

  // Frame bits: 0 ipv4, 1 tagged, 2 broadcast, 3 over storm rate
  task automatic ing(input int p, input logic [7:0] c, input logic [3:0] f);
    logic       hit_d;
    logic       hit_t;
    logic [1:0] q;
    hit_d = c[DSCP_BIT] & f[0];
    hit_t = c[P1P_BIT] & f[1];
    q = (hit_d | hit_t) ? ({1'b0, hit_d} | {hit_t, 1'b0}) : c[PRIO_HI:PRIO_LO];
    @(posedge clk_sys);
    rx_valid[p]      <= 1'b1;
    rx_ipv4[p]       <= f[0];
    rx_tagged[p]     <= f[1];
    rx_bcast[p]      <= f[2];
    rx_storm_over[p] <= f[3];
    rx_dscp_prio[p]  <= 2'b01;
    rx_tag_prio[p]   <= 2'b10;
    @(posedge clk_sys);
    rx_valid[p] <= 1'b0;
    #1;
    check(cls_valid[p], 1'b1);
    check(cls_queue[p], q);
    check(cls_drop[p], c[STORM_BIT] & f[2] & f[3]);
  endtask : ing

  task automatic egr(input int s, input int d, input logic tg,
                     input logic full);
    logic ins;
    logic stp;
    ins = full & ectl[d][INSERT_BIT] & ~tg;
    stp = ectl[d][REMOVE_BIT] & tg;
    @(posedge clk_sys);
    tx_valid     <= 1'b1;
    tx_port      <= d[1:0];
    tx_src_port  <= s[1:0];
    tx_rx_tagged <= tg;
    @(posedge clk_sys);
    tx_valid <= 1'b0;
    #1;
    check(tx_edit_valid, 1'b1);
    check(tx_insert_tag, ins);
    check(tx_strip_tag, stp);
    check(tx_fcs_redo, ins | stp);
    check(tx_tag_vid, vid[s]);
  endtask : egr

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  initial begin
    clk_sys = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = '0; pwdata = '0; pstrb = 4'hf;
    rx_valid = '0; rx_bcast = '0; rx_storm_over = '0; rx_ipv4 = '0;
    rx_tagged = '0; rx_dscp_prio = '0; rx_tag_prio = '0;
    tx_valid = 0; tx_port = '0; tx_src_port = '0; tx_rx_tagged = 0;
    fail_count = 0; samples_checked = 0; cycles = 0;
    ectl = '{8'h04, 8'h02, 8'h06};
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rdchk(CTRL0_OFS[i], 32'h0);
      rdchk(PORT_DEFAULT_VLAN_ID_OFS[i], 32'h1);
    end
    apb(1'b0, 8'h3c, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    // Lane 0 disabled: the 8-bit register must not change
    pstrb <= 4'he;
    apb(1'b1, CTRL0_OFS[0], 32'hff);
    pstrb <= 4'hf;
    rdchk(CTRL0_OFS[0], 32'h0);
    for (int i = 0; i < 3; i++) apb(1'b1, CTRL0_OFS[i], 32'hffffff3c + i);
    for (int i = 0; i < 3; i++) rdchk(CTRL0_OFS[i], 32'h3c + i);
    for (int i = 0; i < 32; i++) begin
      apb(1'b1, CTRL0_OFS[i % 3], {24'h0, i[4:0], 3'b000});
      rdchk(CTRL0_OFS[i % 3], {24'h0, i[4:0], 3'b000});
      for (int f = 0; f < 16; f++) ing(i % 3, {i[4:0], 3'b000}, f[3:0]);
    end
    for (int i = 0; i < 3; i++) begin
      vid[i] = 12'h5a0 + 12'(i * 'h111);
      apb(1'b1, PORT_DEFAULT_VLAN_ID_OFS[i], {20'h0, vid[i]});
      rdchk(PORT_DEFAULT_VLAN_ID_OFS[i], {20'h0, vid[i]});
      apb(1'b1, CTRL0_OFS[i], {24'h0, ectl[i]});
    end
    // Insertion stays off until every setup bit is programmed
    egr(1, 0, 1'b0, 1'b0);
    apb(1'b1, TAG_SETUP_OFS, 32'h3e);
    egr(2, 2, 1'b0, 1'b0);
    apb(1'b1, TAG_SETUP_OFS, 32'h3f);
    for (int s = 0; s < 3; s++)
      for (int d = 0; d < 3; d++)
        for (int t = 0; t < 2; t++) egr(s, d, t[0], 1'b1);
    apb(1'b1, CTRL0_OFS[0], 32'h01);
    apb(1'b1, CTRL0_OFS[1], 32'h00);
    apb(1'b1, CTRL0_OFS[2], 32'h01);
    apb(1'b1, SPLIT2_OFS[1], 32'h80);
    apb(1'b1, SPLIT2_OFS[2], 32'h80);
    repeat (2) @(posedge clk_sys);
    #1;
    check(egress_queue_four_way_split, 3'b101);
    check(egress_queue_two_way_split, 3'b010);
    rdchk(STATUS_OFS, 32'h0000000c);
    apb(1'b1, CTRL0_OFS[0], 32'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    check(egress_queue_four_way_split, 3'b100);
    end_of_test();
  end

endmodule : test_port_ingress_class_egress_tag_ctrl
